// file: tq_cfg.svh
/*
 * Constants of the touch event qualifier: register offsets, reset values,
 * field positions and timing figures.
 * Assumes it is included by every file that uses the macros.
 */
`ifndef TQ_CFG_SVH
`define TQ_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TQ_ADDR_STATUS      8'h00
`define TQ_ADDR_TOUCH       8'h03
`define TQ_ADDR_HOLD        8'h23
`define TQ_ADDR_IRQ_EN      8'h27
`define TQ_ADDR_RPT_EN      8'h28
`define TQ_ADDR_LIMIT       8'h2A
`define TQ_ADDR_PATCFG      8'h2B
`define TQ_ADDR_PATMASK     8'h2D

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TQ_RST_IRQ_EN       8'hFF
`define TQ_RST_RPT_EN       8'hFF
`define TQ_RST_LIMIT        8'h80
`define TQ_RST_PATCFG       8'h00
`define TQ_RST_PATMASK      8'hFF
`define TQ_RST_HOLD         4'h7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TQ_LIMIT_BLK_BIT    7
`define TQ_LIMIT_CNT_HI     3
`define TQ_LIMIT_CNT_LO     2
`define TQ_PAT_EN_BIT       7
`define TQ_PAT_TH_HI        3
`define TQ_PAT_TH_LO        2
`define TQ_PAT_MODE_BIT     1
`define TQ_PAT_ALERT_BIT    0
`define TQ_ST_IRQ_BIT       0
`define TQ_ST_PAT_BIT       1
`define TQ_ST_SEVERAL_TOUCH_FLAG_BIT      2

// ----------------------------------------------------------------------
// Timing and pattern threshold fractions (eighths)
// ----------------------------------------------------------------------
`define TQ_CLK_KHZ          125000
`define TQ_TICK_MS          1
`define TQ_HOLD_STEP_MS     35
`define TQ_REPEAT_MS        175
`define TQ_MS_W             10
`define TQ_MS_MAX           10'h3FF
`define TQ_TICK_W           17
`define TQ_FRAC_SHIFT       3
`define TQ_FRAC_C0          4'h1
`define TQ_FRAC_C1          4'h2
`define TQ_FRAC_C2          4'h3
`define TQ_FRAC_C3          4'h8

`endif

// file: tq_pkg.sv
/*
 * Types of the touch event qualifier.
 * Assumes tq_cfg.svh is on the include path.
 */
`default_nettype none
`include "tq_cfg.svh"

package tq_pkg;

    typedef struct packed {
        logic [7:0]                      irq_enable;
        logic [7:0]                      repeat_enable;
        logic [7:0]                      limit_cfg;
        logic [7:0]                      pattern_cfg;
        logic [7:0]                      pattern_mask;
        logic [3:0]                      hold_sel;
        logic [7:0]                      touch_status;
        logic [7:0]                      held;
        logic [7:0][`TQ_MS_W-1:0]        hold_ms;
        logic [7:0][`TQ_MS_W-1:0]        rep_ms;
        logic [`TQ_TICK_W-1:0]           tick_cnt;
        logic                            tick;
        logic                            pattern_active;
        logic                            pattern_event_flag;
        logic                            several_touch_flag;
        logic                            irq;
        logic [7:0]                      rd_data;
    } tq_state_type;

endpackage : tq_pkg

`default_nettype wire

// file: tq_pattern_match.sv
/*
 * Pattern match of one polling cycle: scales each threshold, marks inputs
 * above it or noisy, then checks that every mask input qualifies, or a minimum count.
 * Assumes all inputs belong to the same polling cycle.
 */
`default_nettype none
`include "tq_cfg.svh"

module tq_pattern_match
    import tq_pkg::*;
(
    input  wire logic [63:0] delta_count,
    input  wire logic [63:0] touch_threshold,
    input  wire logic [7:0]  standby_threshold,
    input  wire logic        standby_active,
    input  wire logic [7:0]  noise_flag,
    input  wire logic [1:0]  pattern_threshold_sel,
    input  wire logic        pattern_match_mode,
    input  wire logic [7:0]  pattern_mask,
    output logic             pattern_hit
);

    logic [3:0] frac;
    logic [7:0] qualified;

    // ------------------------------------------------------------------
    // Threshold fraction in eighths
    // ------------------------------------------------------------------
    always_comb
    begin
        case (pattern_threshold_sel)
            2'b00:   frac = `TQ_FRAC_C0;
            2'b01:   frac = `TQ_FRAC_C1;
            2'b10:   frac = `TQ_FRAC_C2;
            default: frac = `TQ_FRAC_C3;
        endcase
    end

    // ------------------------------------------------------------------
    // Per-input qualification
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_in
            logic [7:0]  base;
            logic [11:0] scaled;
            assign base   = standby_active ? standby_threshold
                                           : touch_threshold[i*8 +: 8];
            assign scaled = (12'(base) * 12'(frac)) >> `TQ_FRAC_SHIFT;
            assign qualified[i] = (12'(delta_count[i*8 +: 8]) > scaled) || noise_flag[i];
        end
    endgenerate

    // Every mask input qualified, or count of qualified inputs against count of mask bits
    always_comb
    begin
        if (pattern_match_mode)
            pattern_hit = ((qualified & pattern_mask) == pattern_mask);
        else
            pattern_hit = ($countones(qualified) >= $countones(pattern_mask));
    end

endmodule : tq_pattern_match

`default_nettype wire

// file: tq_touch_qualifier.sv
/*
 * Touch event qualifier: configuration registers, touch blocking,
 * press-and-hold timing with repeat, pattern blocking and the interrupt.
 * Assumes a polling strobe from the sensing front end with per-input touch
 * decisions, delta counts, thresholds and noise flags valid in that cycle,
 * and a simple register port from the serial interface.
 */
`default_nettype none
`include "tq_cfg.svh"

module tq_touch_qualifier
    import tq_pkg::*;
#(
    parameter int TICK_CYCLES = `TQ_TICK_MS * `TQ_CLK_KHZ
)
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wr_data,
    output logic      [7:0]  reg_rd_data,
    input  wire logic        release_irq_enable,
    input  wire logic        poll_valid,
    input  wire logic [7:0]  touch_detect,
    input  wire logic [63:0] delta_count,
    input  wire logic [63:0] touch_threshold,
    input  wire logic [7:0]  standby_threshold,
    input  wire logic        standby_active,
    input  wire logic [7:0]  noise_flag,
    output logic      [7:0]  touch_status,
    output logic             several_touch_flag,
    output logic             pattern_event_flag,
    output logic             irq
);

    tq_state_type       s;
    tq_state_type       n;
    logic               pattern_hit;
    logic               pat_now;
    logic               irq_clear;
    logic               blocked;
    logic [7:0]         raw;
    logic [7:0]         acc;
    logic [7:0]         touch_evt;
    logic               any_evt;
    logic [3:0]         cnt;
    logic [2:0]         limit;
    logic [`TQ_MS_W-1:0] hold_limit;

    // ------------------------------------------------------------------
    // Pattern detector
    // ------------------------------------------------------------------
    tq_pattern_match u_pattern (
        .delta_count           (delta_count),
        .touch_threshold       (touch_threshold),
        .standby_threshold     (standby_threshold),
        .standby_active        (standby_active),
        .noise_flag            (noise_flag),
        .pattern_threshold_sel (s.pattern_cfg[`TQ_PAT_TH_HI:`TQ_PAT_TH_LO]),
        .pattern_match_mode    (s.pattern_cfg[`TQ_PAT_MODE_BIT]),
        .pattern_mask          (s.pattern_mask),
        .pattern_hit           (pattern_hit)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        n          = s;
        pat_now    = 1'b0;
        blocked    = 1'b0;
        raw        = 8'h00;
        acc        = s.touch_status;
        touch_evt  = 8'h00;
        any_evt    = 1'b0;
        cnt        = 4'h0;
        limit      = 3'(s.limit_cfg[`TQ_LIMIT_CNT_HI:`TQ_LIMIT_CNT_LO]) + 3'h1;
        hold_limit = `TQ_MS_W'((32'(s.hold_sel) + 32'd1) * `TQ_HOLD_STEP_MS);
        irq_clear  = reg_wr_en && (reg_addr == `TQ_ADDR_STATUS)
                     && !reg_wr_data[`TQ_ST_IRQ_BIT];

        // Millisecond tick
        n.tick = 1'b0;
        if (s.tick_cnt == `TQ_TICK_W'(TICK_CYCLES - 1))
        begin
            n.tick_cnt = '0;
            n.tick     = 1'b1;
        end
        else
            n.tick_cnt = s.tick_cnt + `TQ_TICK_W'(1);

        // Register writes
        if (reg_wr_en)
        begin
            if (reg_addr == `TQ_ADDR_HOLD)
                n.hold_sel = reg_wr_data[3:0];
            else if (reg_addr == `TQ_ADDR_IRQ_EN)
                n.irq_enable = reg_wr_data;
            else if (reg_addr == `TQ_ADDR_RPT_EN)
                n.repeat_enable = reg_wr_data;
            else if (reg_addr == `TQ_ADDR_LIMIT)
                n.limit_cfg = reg_wr_data;
            else if (reg_addr == `TQ_ADDR_PATCFG)
                n.pattern_cfg = reg_wr_data;
            else if (reg_addr == `TQ_ADDR_PATMASK)
                n.pattern_mask = reg_wr_data;
        end

        // Hold and repeat timing of accepted touches
        for (int i = 0; i < 8; i++)
        begin
            if (s.touch_status[i])
            begin
                n.held[i] = s.hold_ms[i] > hold_limit;
                if (s.tick && s.hold_ms[i] != `TQ_MS_MAX)
                    n.hold_ms[i] = s.hold_ms[i] + `TQ_MS_W'(1);
                if (s.held[i] && s.repeat_enable[i])
                begin
                    if (s.rep_ms[i] >= `TQ_MS_W'(`TQ_REPEAT_MS))
                    begin
                        n.rep_ms[i]  = '0;
                        touch_evt[i] = s.irq_enable[i];
                    end
                    else if (s.tick)
                        n.rep_ms[i] = s.rep_ms[i] + `TQ_MS_W'(1);
                end
            end
        end

        // Once per polling cycle
        if (poll_valid)
        begin
            pat_now = s.pattern_cfg[`TQ_PAT_EN_BIT] && pattern_hit;
            n.pattern_active = pat_now;
            raw = pat_now ? 8'h00 : touch_detect;
            if (s.limit_cfg[`TQ_LIMIT_BLK_BIT])
            begin
                acc = raw & s.touch_status;
                cnt = 4'($countones(acc));
                for (int i = 0; i < 8; i++)
                begin
                    if (raw[i] && !acc[i])
                    begin
                        if (cnt < 4'(limit))
                        begin
                            acc[i] = 1'b1;
                            cnt    = cnt + 4'h1;
                        end
                        else
                            blocked = 1'b1;
                    end
                end
            end
            else
                acc = raw;
            n.several_touch_flag = blocked;
            for (int i = 0; i < 8; i++)
            begin
                if (acc[i] && !s.touch_status[i])
                    touch_evt[i] = s.irq_enable[i];
                else if (!acc[i] && s.touch_status[i])
                begin
                    touch_evt[i] = s.irq_enable[i] && release_irq_enable
                                   && (!s.repeat_enable[i] || !s.held[i]);
                    n.hold_ms[i] = '0;
                    n.rep_ms[i]  = '0;
                    n.held[i]    = 1'b0;
                end
            end
            n.touch_status = acc;
            if (pat_now && !s.pattern_active && s.pattern_cfg[`TQ_PAT_ALERT_BIT])
                any_evt = 1'b1;
        end

        any_evt = any_evt || (|touch_evt);
        n.irq   = (s.irq && !irq_clear) || any_evt;
        n.pattern_event_flag = (s.pattern_event_flag
                                && !(irq_clear && !s.pattern_active)) || pat_now;

        // Register reads
        if (reg_rd_en)
        begin
            if (reg_addr == `TQ_ADDR_STATUS)
                n.rd_data = {5'h00, s.several_touch_flag, s.pattern_event_flag, s.irq};
            else if (reg_addr == `TQ_ADDR_TOUCH)
                n.rd_data = s.touch_status;
            else if (reg_addr == `TQ_ADDR_HOLD)
                n.rd_data = {4'h0, s.hold_sel};
            else if (reg_addr == `TQ_ADDR_IRQ_EN)
                n.rd_data = s.irq_enable;
            else if (reg_addr == `TQ_ADDR_RPT_EN)
                n.rd_data = s.repeat_enable;
            else if (reg_addr == `TQ_ADDR_LIMIT)
                n.rd_data = s.limit_cfg;
            else if (reg_addr == `TQ_ADDR_PATCFG)
                n.rd_data = s.pattern_cfg;
            else if (reg_addr == `TQ_ADDR_PATMASK)
                n.rd_data = s.pattern_mask;
            else
                n.rd_data = 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s               <= '0;
            s.irq_enable    <= `TQ_RST_IRQ_EN;
            s.repeat_enable <= `TQ_RST_RPT_EN;
            s.limit_cfg     <= `TQ_RST_LIMIT;
            s.pattern_cfg   <= `TQ_RST_PATCFG;
            s.pattern_mask  <= `TQ_RST_PATMASK;
            s.hold_sel      <= `TQ_RST_HOLD;
        end
        else if (ce)
            s <= n;
    end

    assign reg_rd_data        = s.rd_data;
    assign touch_status       = s.touch_status;
    assign several_touch_flag = s.several_touch_flag;
    assign pattern_event_flag = s.pattern_event_flag;
    assign irq                = s.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_reset_defaults;
        @(posedge core_clk) disable iff (1'b0) rst |=> (s.irq_enable == `TQ_RST_IRQ_EN)
            && (s.pattern_mask == `TQ_RST_PATMASK) && (s.limit_cfg == `TQ_RST_LIMIT);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("register defaults wrong after reset");

    property p_enable_gate;
        ce && poll_valid && (s.irq_enable == 8'h00) |-> (touch_evt == 8'h00);
    endproperty
    a_enable_gate: assert property (p_enable_gate)
        else $error("touch event raised on a disabled input");

    property p_limit;
        ce && poll_valid && s.limit_cfg[`TQ_LIMIT_BLK_BIT]
            |=> ($countones(s.touch_status) <= int'(3'($past(limit))));
    endproperty
    a_limit: assert property (p_limit)
        else $error("more touches accepted than the limit");

    property p_no_block;
        ce && poll_valid && !s.limit_cfg[`TQ_LIMIT_BLK_BIT] && !pat_now
            |=> (s.touch_status == $past(touch_detect)) && !s.several_touch_flag;
    endproperty
    a_no_block: assert property (p_no_block)
        else $error("touch blocked with blocking disabled");

    property p_pattern_block;
        ce && poll_valid && pat_now |=> (s.touch_status == 8'h00) && s.pattern_event_flag;
    endproperty
    a_pattern_block: assert property (p_pattern_block)
        else $error("pattern event did not block and flag");

    property p_pattern_off;
        ce && poll_valid && !s.pattern_cfg[`TQ_PAT_EN_BIT] |=> !s.pattern_active;
    endproperty
    a_pattern_off: assert property (p_pattern_off)
        else $error("pattern active while disabled");

    property p_flag_kept;
        s.pattern_event_flag && s.pattern_active |=> s.pattern_event_flag;
    endproperty
    a_flag_kept: assert property (p_flag_kept)
        else $error("pattern flag cleared while condition persists");

    property p_quiet;
        ce && !s.irq && !any_evt |=> !s.irq;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("interrupt raised without an enabled event");

    property p_irq_set;
        ce && any_evt |=> s.irq ##1 (s.irq || $past(ce && irq_clear));
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("interrupt did not hold after an event");

    sequence s_release0;
        ce && poll_valid && s.touch_status[0] && !touch_detect[0];
    endsequence
    sequence s_cleared0;
        !s.touch_status[0] && (s.hold_ms[0] == '0) && !s.held[0];
    endsequence
    property p_release_clears;
        s_release0 |=> s_cleared0;
    endproperty
    a_release_clears: assert property (p_release_clears)
        else $error("released input kept its hold state");

endmodule : tq_touch_qualifier

`default_nettype wire

// file: tq_host_model.sv
/*
 * Host controller model: register writes and reads with one-cycle strobes.
 * Assumes the bench clock and one caller at a time.
 */
`default_nettype none
module tq_host_model
(
    input  wire logic       core_clk,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wr_data,
    input  wire logic [7:0] reg_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = 18'h0;
    // Released write data is inverted so a stale byte is never mistaken for a fresh one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        {reg_wr_en, reg_addr, reg_wr_data} = {1'b1, a, d};
        @(negedge core_clk);
        {reg_wr_en, reg_wr_data} = {1'b0, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        {reg_rd_en, reg_addr} = {1'b1, a};
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        d = reg_rd_data;
    endtask : rd
endmodule : tq_host_model
`default_nettype wire

// file: tq_touch_qualifier_test.sv
/*
 * Bench of the touch event qualifier: defaults, limits, interrupts, hold and
 * repeat timing, pattern detection. Assumes tq_host_model and a 4-cycle tick.
 */
`default_nettype none
`define TQ_CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tq_touch_qualifier_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 8 * 35 * 4;
    localparam int RPT  = 175 * 4;
    localparam logic [55:0] RST_ADDR = 56'h2327282A2B2D50;
    localparam logic [55:0] RST_VAL  = 56'h07FFFF8000FF00;
    logic        core_clk, rst = 1'b1, release_irq_enable = 1'b0, poll_valid = 1'b0;
    logic        standby_active = 1'b0, reg_wr_en, reg_rd_en, irq;
    logic        several_touch_flag, pattern_event_flag;
    logic [7:0]  reg_addr, reg_wr_data, reg_rd_data, touch_status, t, en, cfg, ex, rv;
    logic [7:0]  touch_detect = 8'h00, noise_flag = 8'h00;
    logic [63:0] delta_count = 64'h0;
    int          err_count = 0, total_checks = 0, n;
    tq_touch_qualifier #(.TICK_CYCLES(4)) i_tq_touch_qualifier
    (
        .core_clk(core_clk), .rst(rst), .ce(1'b1), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .release_irq_enable(release_irq_enable),
        .poll_valid(poll_valid), .touch_detect(touch_detect), .delta_count(delta_count),
        .touch_threshold({8{8'h40}}), .standby_threshold(8'h80),
        .standby_active(standby_active), .noise_flag(noise_flag),
        .touch_status(touch_status), .several_touch_flag(several_touch_flag),
        .pattern_event_flag(pattern_event_flag), .irq(irq)
    );
    tq_host_model i_tq_host_model
    (
        .core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data)
    );
    // First touches in input order, up to the limit code plus one
    function automatic logic [7:0] exp_limit(logic [7:0] s, logic [1:0] c);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++)
            if (s[i] && $countones(r) <= c)
                r[i] = 1'b1;
        return r;
    endfunction : exp_limit
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        i_tq_host_model.wr(a, d);
    endtask : w
    // One poll pulse, then an idle cycle so the registered outputs have landed
    task automatic poll(input logic [7:0] s);
        @(negedge core_clk);
        {poll_valid, touch_detect} = {1'b1, s};
        @(negedge core_clk);
        poll_valid = 1'b0;
        @(negedge core_clk);
    endtask : poll
    // Keeps the touch polled every 8 cycles and counts cycles until irq
    task automatic wait_irq(input int lim);
        n = 0;
        while (irq !== 1'b1 && n < lim)
        begin
            @(negedge core_clk);
            poll_valid = (n % 8 == 0);
            n++;
        end
        @(negedge core_clk);
        poll_valid = 1'b0;
    endtask : wait_irq
    task automatic pat(input logic [7:0] c, input logic [63:0] d, input logic [7:0] nz,
                       input logic e);
        w(8'h2B, c);
        {delta_count, noise_flag} = 72'h0;
        poll(8'h0F);
        w(8'h00, 8'h00); // clear only after the condition is gone
        {delta_count, noise_flag} = {d, nz};
        poll(8'h0F);
        `TQ_CHK("pattern flag", e, pattern_event_flag)
        `TQ_CHK("blocked touches", e ? 8'h00 : 8'h0F, touch_status)
        `TQ_CHK("pattern irq", e & c[0], irq)
        {delta_count, noise_flag} = 72'h0;
        poll(8'h0F);
        `TQ_CHK("sticky flag", e, pattern_event_flag)
        `TQ_CHK("restored touches", 8'h0F, touch_status)
    endtask : pat
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        summarize();
    end
    initial
    begin
        void'($urandom(55));
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        for (int k = 0; k < 7; k++)
        begin
            i_tq_host_model.rd(RST_ADDR[55 - 8 * k -: 8], rv);
            `TQ_CHK("reset value", RST_VAL[55 - 8 * k -: 8], rv)
        end
        $display("test defaults done");
        for (int k = 0; k < 30; k++)
        begin
            t = k < 4 ? 8'hFF : 8'($urandom);
            en = 8'($urandom);
            cfg = k < 4 ? {3'b100, 3'h0, 2'(k), 2'b00} : 8'($urandom) & 8'h8C;
            poll(8'h00);
            w(8'h00, 8'h00);
            w(8'h2A, cfg);
            `TQ_CHK("irq cleared", 1'b0, irq)
            w(8'h27, en);
            poll(t);
            ex = cfg[7] ? exp_limit(t, cfg[3:2]) : t;
            `TQ_CHK("accepted touches", ex, touch_status)
            `TQ_CHK("limit flag", ex != t, several_touch_flag)
            `TQ_CHK("touch irq", |(ex & en), irq)
        end
        w(8'h2A, 8'h80);
        poll(8'h02);
        poll(8'h03);
        `TQ_CHK("kept input", 8'h02, touch_status)
        poll(8'h01);
        `TQ_CHK("refilled input", 8'h01, touch_status)
        $display("test limits done");
        release_irq_enable = 1'b1;
        w(8'h27, 8'hFF);
        for (int k = 0; k < 2; k++)
        begin
            w(8'h28, k ? 8'hFF : 8'h00);
            poll(8'h00);
            w(8'h00, 8'h00);
            poll(8'h01);
            `TQ_CHK("touch irq", 1'b1, irq)
            w(8'h00, 8'h00);
            poll(8'h00);
            `TQ_CHK("release irq", 1'b1, irq)
        end
        w(8'h00, 8'h00);
        poll(8'h01);
        w(8'h00, 8'h00);
        wait_irq(HOLD + RPT + 100);
        `TQ_CHK("hold irq time", 1'b1, n > HOLD + RPT - 40 && n < HOLD + RPT + 40)
        w(8'h00, 8'h00);
        wait_irq(RPT + 100);
        `TQ_CHK("repeat irq time", 1'b1, n > RPT - 40 && n < RPT + 40)
        w(8'h28, 8'h00);
        poll(8'h00);
        w(8'h00, 8'h00);
        poll(8'h01);
        w(8'h00, 8'h00);
        wait_irq(HOLD + RPT + 100);
        `TQ_CHK("no repeat irq", 1'b0, irq)
        $display("test hold done");
        release_irq_enable = 1'b0;
        w(8'h27, 8'h00);
        w(8'h2A, 8'h00);
        w(8'h2D, 8'h03);
        for (int c = 0; c < 4; c++)
        begin
            ex = c == 3 ? 8'h40 : 8'(8 * (c + 1));
            cfg = {4'b1000, 2'(c), 2'b01};
            pat(cfg, {32'h0, ex + 8'h01, ex + 8'h01, 16'h0}, 8'h00, 1'b1);
            pat(cfg, {32'h0, ex, ex, 16'h0}, 8'h00, 1'b0);
        end
        pat(8'h83, {32'h0, 16'h0909, 16'h0}, 8'h00, 1'b0);
        pat(8'h83, {48'h0, 16'h0909}, 8'h00, 1'b1);
        pat(8'h83, 64'h0, 8'h03, 1'b1);
        pat(8'h80, {48'h0, 16'h0909}, 8'h00, 1'b1);
        pat(8'h01, {48'h0, 16'h0909}, 8'h00, 1'b0);
        standby_active = 1'b1;
        pat(8'h81, {48'h0, 16'h0909}, 8'h00, 1'b0);
        $display("test pattern done");
        summarize();
    end
endmodule : tq_touch_qualifier_test
`default_nettype wire
